// ### src/pic_pkg.sv
// constants, register map and helpers for the phy interrupt and extended control block
package pic_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;
	localparam int SRC_W  = 15;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_EXT_CTL_ONE = 6'h17;
	localparam logic [5:0] IDX_EXT_CTL_TWO = 6'h18;
	localparam logic [5:0] IDX_INT_MASK    = 6'h19;
	localparam logic [5:0] IDX_INT_STATUS  = 6'h1A;

	// field positions
	localparam int FAR_LB_BIT   = 3;
	localparam int EDGE_HI      = 15;
	localparam int EDGE_LO      = 13;
	localparam int JUMBO_HI     = 5;
	localparam int JUMBO_LO     = 4;
	localparam int CABLE_LB_BIT = 0;
	localparam int INT_EN_BIT   = 15;
	localparam int SUMMARY_BIT  = 15;

	// reset values and field encodings
	localparam logic [2:0] EDGE_RST     = 3'h0;
	localparam logic [1:0] JUMBO_RST    = 2'h0;
	localparam logic [1:0] JUMBO_1518   = 2'h0;
	localparam logic [1:0] JUMBO_9000   = 2'h1;
	localparam logic [1:0] JUMBO_12000  = 2'h2;
	localparam logic [1:0] JUMBO_RSVD   = 2'h3;
	localparam logic [15:0] MASK_RST    = 16'h0000;
	localparam logic [14:0] PEND_RST    = 15'h0000;
	// bit 6 is reserved in both mask and status
	localparam logic [14:0] SRC_VALID   = 15'h7FBF;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction : reg_addr

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [REG_W-1:0] lane_merge(input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] data, input logic [1:0] strb);
		lane_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction : lane_merge
endpackage : pic_pkg

// ### src/pic_regs_if.sv
// register access strobes between the bus slave and the register core
`timescale 1ns/10ps
interface pic_regs_if;
	import pic_pkg::*;
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [REG_W-1:0]  wr_data;
	logic [1:0]        wr_strb;
	logic              wr_ok;
	logic              rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [REG_W-1:0]  rd_data;
	logic              rd_ok;

	modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
	              input wr_ok, rd_data, rd_ok);
	modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
	              output wr_ok, rd_data, rd_ok);
endinterface : pic_regs_if

// ### src/pic_axil_slave.sv
// axi4-lite slave that turns bus transfers into register strobes
`timescale 1ns/10ps
module pic_axil_slave
	import pic_pkg::*;
(
	// clock, reset, enable
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// write address and data
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	// write response
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	// read
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [DATA_W-1:0]      rdata,
	output logic [1:0]             rresp,
	// register core
	pic_regs_if.bus                rg
);
	logic              awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
	logic              aw_held_ff, w_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [REG_W-1:0]  wdata_ff;
	logic [1:0]        wstrb_ff, bresp_ff, rresp_ff;
	logic [DATA_W-1:0] rdata_ff;

	// handshakes and next states
	wire aw_fire      = awvalid & awready_ff;
	wire w_fire       = wvalid & wready_ff;
	wire ar_fire      = arvalid & arready_ff;
	wire do_wr        = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire nxt_aw_held  = aw_fire | (aw_held_ff & ~do_wr);
	wire nxt_w_held   = w_fire | (w_held_ff & ~do_wr);
	wire nxt_bvalid   = do_wr | (bvalid_ff & ~bready);
	wire nxt_rvalid   = ar_fire | (rvalid_ff & ~rready);

	// strobes to the core, frozen with the clock enable
	assign rg.wr_en   = do_wr & ce;
	assign rg.wr_addr = awaddr_ff;
	assign rg.wr_data = wdata_ff;
	assign rg.wr_strb = wstrb_ff;
	assign rg.rd_en   = ar_fire & ce;
	assign rg.rd_addr = araddr;

	// write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
		end else if (ce) begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			bvalid_ff  <= nxt_bvalid;
			awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
			if (aw_fire) awaddr_ff <= awaddr;
			if (w_fire) begin
				wdata_ff <= wdata[REG_W-1:0];
				wstrb_ff <= wstrb[1:0];
			end
			if (do_wr) bresp_ff <= rg.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// read side; data captured at the taking edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (ce) begin
			rvalid_ff  <= nxt_rvalid;
			arready_ff <= ~nxt_rvalid;
			if (ar_fire) begin
				rdata_ff <= {{(DATA_W-REG_W){1'b0}}, rg.rd_data};
				rresp_ff <= rg.rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
endmodule : pic_axil_slave

// ### src/pic_top.sv
// phy extended control registers and masked interrupt facility
//
// Summary of operation
// - control one bit 3 is far-end loopback enable, reset 0; rest reserved
// - control two bits 15:13 pick transmit edge rate, reset 000
// - control two bits 5:4 pick packet length 1518/9000/12000, 11 reserved
// - control two bit 0 is cable loopback enable; 12:6 and 3:1 reserved
// - mask bit 15 is master enable; clear keeps summary and irq low
// - mask bits 14:0 unmask one source each, bit 6 reserved, reset 0
// - status bits mirror mask positions, bit 15 summary, bit 6 reserved
// - a masked source never shows in its status bit
// - masked sources still latch their event in a pending flag
// - setting a mask bit exposes an already pending condition
// - status read clears pending only for sources unmasked at the read
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module pic_top
	import pic_pkg::*;
(
	// clock, reset, enable
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// axi4-lite write
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// axi4-lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// interrupt source events, one-cycle pulses from the phy datapath
	input  wire logic [SRC_W-1:0]  src_event,
	// control outputs to the datapath
	output logic                   far_loopback_en,
	output logic [2:0]             tx_edge_rate,
	output logic [1:0]             jumbo_len_sel,
	output logic                   cable_loopback_en,
	// interrupt
	output logic                   irq
);
	pic_regs_if rg ();

	logic             far_lb_ff;
	logic [2:0]       edge_ff;
	logic [1:0]       jumbo_ff;
	logic             cable_ff;
	logic [REG_W-1:0] mask_ff;
	logic [SRC_W-1:0] pend_ff;
	logic             irq_ff;

	pic_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.awaddr  (s_axi_awaddr),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.bresp   (s_axi_bresp),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.araddr  (s_axi_araddr),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rg      (rg)
	);

	// write address decode
	wire wr_ext1 = rg.wr_en & (rg.wr_addr == reg_addr(IDX_EXT_CTL_ONE));
	wire wr_ext2 = rg.wr_en & (rg.wr_addr == reg_addr(IDX_EXT_CTL_TWO));
	wire wr_mask = rg.wr_en & (rg.wr_addr == reg_addr(IDX_INT_MASK));
	wire wr_stat = rg.wr_en & (rg.wr_addr == reg_addr(IDX_INT_STATUS));

	// read address decode
	wire rd_ext1 = rg.rd_addr == reg_addr(IDX_EXT_CTL_ONE);
	wire rd_ext2 = rg.rd_addr == reg_addr(IDX_EXT_CTL_TWO);
	wire rd_mask = rg.rd_addr == reg_addr(IDX_INT_MASK);
	wire rd_stat = rg.rd_addr == reg_addr(IDX_INT_STATUS);
	wire status_read = rg.rd_en & rd_stat;

	assign rg.wr_ok = wr_ext1 | wr_ext2 | wr_mask | wr_stat;
	assign rg.rd_ok = rd_ext1 | rd_ext2 | rd_mask | rd_stat;

	// register images as software sees them
	wire [REG_W-1:0] ext1_word = {{(REG_W-FAR_LB_BIT-1){1'b0}}, far_lb_ff,
	                              {FAR_LB_BIT{1'b0}}};
	wire [REG_W-1:0] ext2_word = {edge_ff, 7'h00, jumbo_ff, 3'h0, cable_ff};
	wire [SRC_W-1:0] vis_stat  = pend_ff & mask_ff[SRC_W-1:0] & SRC_VALID;
	wire             summary   = mask_ff[INT_EN_BIT] & (|vis_stat);
	wire [REG_W-1:0] stat_word = {summary, vis_stat};

	assign rg.rd_data = rd_ext1 ? ext1_word :
	                    rd_ext2 ? ext2_word :
	                    rd_mask ? mask_ff   :
	                    rd_stat ? stat_word : {REG_W{1'b0}};

	// write merges with byte lanes
	wire [REG_W-1:0] ext1_new = lane_merge(ext1_word, rg.wr_data, rg.wr_strb);
	wire [REG_W-1:0] ext2_new = lane_merge(ext2_word, rg.wr_data, rg.wr_strb);
	wire [REG_W-1:0] mask_new = lane_merge(mask_ff, rg.wr_data, rg.wr_strb);
	wire [REG_W-1:0] w1c_bits = lane_merge({REG_W{1'b0}}, rg.wr_data, rg.wr_strb);
	wire [1:0]       jumbo_wr = ext2_new[JUMBO_HI:JUMBO_LO];

	// next values of mask and pending flags
	wire [REG_W-1:0] nxt_mask = wr_mask ? (mask_new & {1'b1, SRC_VALID}) : mask_ff;
	wire [SRC_W-1:0] rd_clr   = status_read ? mask_ff[SRC_W-1:0] : {SRC_W{1'b0}};
	wire [SRC_W-1:0] wr_clr   = wr_stat ? (w1c_bits[SRC_W-1:0] & mask_ff[SRC_W-1:0])
	                                    : {SRC_W{1'b0}};
	// events latch regardless of mask, and a set wins over a clear
	wire [SRC_W-1:0] nxt_pend = ((pend_ff & ~(rd_clr | wr_clr)) | src_event) & SRC_VALID;
	wire             nxt_irq  = nxt_mask[INT_EN_BIT] &
	                            (|(nxt_pend & nxt_mask[SRC_W-1:0]));

	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			far_lb_ff <= 1'b0;
			edge_ff   <= EDGE_RST;
			jumbo_ff  <= JUMBO_RST;
			cable_ff  <= 1'b0;
		end else if (ce) begin
			if (wr_ext1) far_lb_ff <= ext1_new[FAR_LB_BIT];
			if (wr_ext2) begin
				edge_ff  <= ext2_new[EDGE_HI:EDGE_LO];
				cable_ff <= ext2_new[CABLE_LB_BIT];
				if (jumbo_wr != JUMBO_RSVD) jumbo_ff <= jumbo_wr;
			end
		end
	end

	// mask, pending flags and interrupt line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_ff <= MASK_RST;
			pend_ff <= PEND_RST;
			irq_ff  <= 1'b0;
		end else if (ce) begin
			mask_ff <= nxt_mask;
			pend_ff <= nxt_pend;
			irq_ff  <= nxt_irq;
		end
	end

	assign far_loopback_en   = far_lb_ff;
	assign tx_edge_rate      = edge_ff;
	assign jumbo_len_sel     = jumbo_ff;
	assign cable_loopback_en = cable_ff;
	assign irq               = irq_ff;
endmodule : pic_top

// ### testbench/pic_top_monitor.sv
// port assertions for the phy interrupt and extended control block
`timescale 1ns/10ps
module pic_top_monitor
	import pic_pkg::*;
(
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// register bus
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_rvalid,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_bvalid,
	// events and outputs
	input wire logic [SRC_W-1:0]  src_event,
	input wire logic              far_loopback_en,
	input wire logic [2:0]        tx_edge_rate,
	input wire logic [1:0]        jumbo_len_sel,
	input wire logic              cable_loopback_en,
	input wire logic              irq
);
	logic [5:0] rd_idx_ff;
	wire        rd_take = s_axi_arvalid && s_axi_arready;
	wire        st_rd   = rd_idx_ff == IDX_INT_STATUS;
	// index of the register under read
	always_ff @(posedge aclk) begin
		if (rd_take) begin
			rd_idx_ff <= s_axi_araddr[7:2];
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_ctl1_rsvd;
		s_axi_rvalid && rd_idx_ff == IDX_EXT_CTL_ONE |-> (s_axi_rdata[15:0] & 16'hFFF7) == 16'h0000;
	endproperty
	a_ctl1_rsvd: assert property (p_ctl1_rsvd) else $error("control one reserved set");
	property p_ctl2_rsvd;
		s_axi_rvalid && rd_idx_ff == IDX_EXT_CTL_TWO |-> (s_axi_rdata[15:0] & 16'h1FCE) == 16'h0000;
	endproperty
	a_ctl2_rsvd: assert property (p_ctl2_rsvd) else $error("control two reserved set");
	property p_jumbo;
		jumbo_len_sel != JUMBO_RSVD;
	endproperty
	a_jumbo: assert property (p_jumbo) else $error("jumbo field reserved code");
	property p_bit6;
		s_axi_rvalid && (rd_idx_ff == IDX_INT_MASK || st_rd) |-> !s_axi_rdata[6];
	endproperty
	a_bit6: assert property (p_bit6) else $error("reserved bit 6 set");
	property p_summary;
		$rose(s_axi_rvalid) && st_rd |-> s_axi_rdata[SUMMARY_BIT] == $past(irq);
	endproperty
	a_summary: assert property (p_summary) else $error("summary differs from irq");
	property p_irq_cause;
		$rose(irq) |-> $past(|src_event) || $rose(s_axi_bvalid);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
	property p_ctl_hold;
		!$rose(s_axi_bvalid) |-> $stable({far_loopback_en, tx_edge_rate, jumbo_len_sel,
			cable_loopback_en});
	endproperty
	a_ctl_hold: assert property (p_ctl_hold) else $error("control moved without write");
	property p_rd_clear;
		rd_take && s_axi_araddr[7:2] == IDX_INT_STATUS && src_event == 15'h0000
			##1 !$rose(s_axi_bvalid) |-> !irq;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("irq kept after status read");
endmodule : pic_top_monitor
bind pic_top pic_top_monitor pic_top_monitor_inst (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid, .src_event,
	.far_loopback_en, .tx_edge_rate, .jumbo_len_sel, .cable_loopback_en, .irq);

// ### testbench/pic_mgmt_master.sv
// management master model on the axi4-lite register port
`timescale 1ns/10ps
module pic_mgmt_master
	import pic_pkg::*;
(
	// clock
	input wire logic         aclk,
	// write channels
	output logic             s_axi_awvalid,
	input wire logic         s_axi_awready,
	output logic [ADDR_W-1:0] s_axi_awaddr,
	output logic             s_axi_wvalid,
	input wire logic         s_axi_wready,
	output logic [DATA_W-1:0] s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	input wire logic         s_axi_bvalid,
	output logic             s_axi_bready,
	// read channels
	output logic             s_axi_arvalid,
	input wire logic         s_axi_arready,
	output logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic         s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus from time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
	end
	// one write; released payload turns to its inverse
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'hF;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~{16'h0000, d};
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	// one read; data is judged by the bench
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : pic_mgmt_master

// ### testbench/testbench.sv
// self-checking bench for the phy interrupt and extended control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module testbench
	import pic_pkg::*;
;
	localparam logic [7:0] A2 = {IDX_EXT_CTL_TWO, 2'b00};
	localparam logic [7:0] AM = {IDX_INT_MASK, 2'b00};
	localparam logic [7:0] AS = {IDX_INT_STATUS, 2'b00};
	int n_mismatch = 0;
	int cmp_count = 0;
	int seed = 32'hd80b;
	int i;
	logic [33:0] exp_q[$];
	logic [33:0] note;
	logic [1:0] bexp_q[$];
	logic [1:0] bnote;
	logic aclk = 1'b0;
	logic aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic far_loopback_en, cable_loopback_en, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [2:0] tx_edge_rate;
	logic [1:0] s_axi_bresp, s_axi_rresp, jumbo_len_sel, j;
	logic [14:0] src_event, e;
	logic [15:0] d;
	pic_top pic_top_inst (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .src_event, .far_loopback_en,
		.tx_edge_rate, .jumbo_len_sel, .cable_loopback_en, .irq);
	pic_mgmt_master pic_mgmt_master_inst (.aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready);
	// 100 ns clock
	always #50 aclk = ~aclk;
	// each read answer against the oldest note
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			note = exp_q.pop_front();
			`CHK("read", note, {s_axi_rresp, s_axi_rdata})
		end
		// each write response against the oldest write note
		if (s_axi_bvalid && s_axi_bready) begin
			bnote = bexp_q.pop_front();
			`CHK("bresp", bnote, s_axi_bresp)
		end
	end
	task automatic rx(input logic [7:0] a, input logic [15:0] v);
		exp_q.push_back({RESP_OKAY, 16'h0000, v});
		pic_mgmt_master_inst.rd(a);
	endtask : rx
	task automatic wx(input logic [7:0] a, input logic [15:0] v);
		bexp_q.push_back(RESP_OKAY);
		pic_mgmt_master_inst.wr(a, v);
	endtask : wx
	// one-cycle event pulse, returns once settled
	task automatic ev(input logic [14:0] v);
		@(posedge aclk);
		src_event <= v;
		@(posedge aclk);
		src_event <= 15'h0000;
		@(negedge aclk);
	endtask : ev
	task end_of_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#500000;
		n_mismatch++;
		end_of_test();
	end
	// main sequence
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		src_event = 15'h0000;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 4; i++) rx({IDX_EXT_CTL_ONE + 6'(i), 2'b00}, 16'h0000);
		wx({IDX_EXT_CTL_ONE, 2'b00}, 16'hFFFF);
		rx({IDX_EXT_CTL_ONE, 2'b00}, 16'h0008);
		`CHK("far", 1'b1, far_loopback_en)
		for (i = 0; i < 8; i++) begin
			j = 2'($unsigned($random(seed)) % 3);
			d = {i[2:0], 7'h7F, j, 3'h7, i[0]};
			wx(A2, d);
			rx(A2, d & 16'hE031);
			`CHK("edge", i[2:0], tx_edge_rate)
			`CHK("jumbo", j, jumbo_len_sel)
			`CHK("cable", d[0], cable_loopback_en)
		end
		wx(A2, 16'h0030);
		rx(A2, {10'h000, j, 4'h0});
		exp_q.push_back({RESP_SLVERR, 32'h00000000});
		pic_mgmt_master_inst.rd(8'h00);
		// unmapped write is refused and changes nothing
		bexp_q.push_back(RESP_SLVERR);
		pic_mgmt_master_inst.wr(8'h00, 16'hFFFF);
		ev(15'h7FFF);
		rx(AS, 16'h0000);
		wx(AM, 16'h7FBF);
		`CHK("irq", 1'b0, irq)
		rx(AS, 16'h7FBF);
		rx(AS, 16'h0000);
		wx(AM, 16'hFFFF);
		rx(AM, 16'hFFBF);
		e = 15'($random(seed)) | 15'h0001;
		ev(e);
		`CHK("irq", 1'b1, irq)
		rx(AS, {1'b1, e & 15'h7FBF});
		`CHK("irq", 1'b0, irq)
		wx(AM, 16'h8001);
		ev(15'h0003);
		rx(AS, 16'h8001);
		wx(AM, 16'h8003);
		`CHK("irq", 1'b1, irq)
		rx(AS, 16'h8002);
		// write-one-to-clear on an unmasked source drops the line
		ev(15'h0002);
		`CHK("irq", 1'b1, irq)
		wx(AS, 16'h0002);
		`CHK("irq", 1'b0, irq)
		rx(AS, 16'h0000);
		// event while the clock enable is low leaves all state frozen
		ce <= 1'b0;
		ev(15'h0001);
		@(posedge aclk);
		ce <= 1'b1;
		@(negedge aclk);
		`CHK("irq", 1'b0, irq)
		rx(AS, 16'h0000);
		end_of_test();
	end
endmodule : testbench
